// ==== rtl/srtim_pkg.sv ====
// Shared constants for the reset, tick timer and interrupt manager
package srtim_pkg;
   // Timing
   localparam int CLK_NS = 50;
   localparam int RST_HOLD_NS = 200;
   localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int RCNT_W = 3;
   // Widths
   localparam int IRQ_NUM_W = 5;
   localparam int PRI_W = 8;
   localparam int CAUSE_W = 8;
   // Register offsets (byte addresses)
   localparam logic [7:0] A_CAUSE = 8'h00;
   localparam logic [7:0] A_SWRST = 8'h04;
   localparam logic [7:0] A_BOOT = 8'h08;
   localparam logic [7:0] A_TCTRL = 8'h10;
   localparam logic [7:0] A_TRLD = 8'h14;
   localparam logic [7:0] A_TCUR = 8'h18;
   localparam logic [7:0] A_SETEN = 8'h20;
   localparam logic [7:0] A_CLREN = 8'h24;
   localparam logic [7:0] A_SETPND = 8'h28;
   localparam logic [7:0] A_CLRPND = 8'h2C;
   localparam logic [7:0] A_ACT = 8'h30;
   localparam logic [7:0] A_PRI0 = 8'h40;
   // Reset cause flag positions
   localparam int CB_POR = 0;
   localparam int CB_PIN = 1;
   localparam int CB_WDT = 2;
   localparam int CB_LVR = 3;
   localparam int CB_BOD = 4;
   localparam int CB_SYSREQ = 5;
   localparam int CB_CORE = 6;
   localparam int CB_CHIP = 7;
   localparam logic [CAUSE_W-1:0] CAUSE_RST = 8'h01;
   // Software reset request bits
   localparam int SW_SYSREQ = 2;
   localparam int SW_CORE = 1;
   localparam int SW_CHIP = 0;
   // Other fields
   localparam int BOOT_SEL_BIT = 1;
   localparam int TICK_EN_BIT = 0;
   localparam int TICK_FLAG_BIT = 16;
   // Reset kinds: which domains a reset reaches
   localparam int K_CORE = 0;
   localparam int K_PERIPH = 1;
   localparam int K_XTAL = 2;
   // Vector table
   localparam logic [31:0] VEC_BASE = 32'h00000000;
   localparam int VEC_EXT_FIRST = 16;
   localparam int VEC_WORD_B = 4;
endpackage

// ==== rtl/srtim_tick_if.sv ====
// Control and status bundle between the manager and its tick counter
`timescale 1ns/1ps
`default_nettype none
interface srtim_tick_if #(parameter int W = 24);
   logic en;
   logic cur_wr;
   logic [W-1:0] reload;
   logic [W-1:0] count;
   logic zero;
   modport dev (input en, input cur_wr, input reload, output count, output zero);
   modport ctl (output en, output cur_wr, output reload, input count, input zero);
endinterface
`default_nettype wire

// ==== rtl/srtim_tick.sv ====
// Decrementing tick counter with reload on zero
`timescale 1ns/1ps
`default_nettype none
module srtim_tick
   import srtim_pkg::*;
#(
   parameter int TW = 24
)(
   input wire logic clk_i,
   input wire logic rst_i,
   srtim_tick_if.dev t
);

   logic [TW-1:0] cnt_q;
   logic zero_q;

   ////////////////////////////////////////////////////////////////////////
   // Counter
   always_ff @(posedge clk_i)
   begin
      if (rst_i || t.cur_wr)
      begin
         cnt_q <= '0;
      end
      else if (t.en)
      begin
         if (cnt_q == '0)
         begin
            cnt_q <= t.reload;
         end
         else
         begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Zero reached: only a real transition, so a zero reload never fires
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         zero_q <= 1'b0;
      end
      else
      begin
         zero_q <= ~t.cur_wr && t.en && (cnt_q == TW'(1));
      end
   end

   assign t.count = cnt_q;
   assign t.zero = zero_q;

endmodule
`default_nettype wire

// ==== rtl/srtim_top.sv ====
// Reset collector, tick timer and interrupt controller behind Wishbone
//
// How it works
// - Reset cause register records power-on, pin, watchdog, low-voltage, brown-out.
// - Three software reset requests: system, core one-shot, chip one-shot.
// - Power-on or chip one-shot resets peripherals, crystal circuit and boot bit.
// - System reset request resets peripherals, spares crystal circuit and boot bit.
// - Tick timer is 24-bit down counter; writing current value clears it.
// - Enabled timer counts to zero, reloads next clock, then keeps decrementing.
// - Zero flag sets when counter transitions to zero.
// - Reading the zero flag clears it.
// - Current value resets to zero; software can also clear it before enabling.
// - Zero reload value holds counter at zero, effectively disabled.
// - Vector table at address zero; word 0 stack pointer, then handlers.
// - Set-enable and clear-enable write-one registers read back enable state.
// - Disabled interrupt still goes pending and leaves arbitration; an offer already out still activates on accept.
// - Active interrupt stays active when disabled until reset or return.
// - Set-pending and clear-pending write-one registers read back pending state.
// - Clearing pending never changes an active interrupt's state.
// - 8-bit priority per interrupt, four packed in each word.
`timescale 1ns/1ps
`default_nettype none
module srtim_top
   import srtim_pkg::*;
#(
   parameter int NIRQ = 8,
   parameter int TW = 24
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic external_reset_pin_low_i,
   input wire logic watchdog_timeout_reset_i,
   input wire logic low_voltage_reset_i,
   input wire logic brownout_reset_i,
   output logic core_rst_o,
   output logic periph_rst_o,
   output logic xtal_rst_o,
   output logic boot_select_bit_o,
   output logic tick_zero_o,
   input wire logic [NIRQ-1:0] irq_src_i,
   output logic irq_req_o,
   output logic [IRQ_NUM_W-1:0] irq_num_o,
   output logic [31:0] vector_addr_o,
   input wire logic irq_accept_i,
   input wire logic exc_return_i,
   input wire logic [IRQ_NUM_W-1:0] exc_return_num_i
);

   localparam int NPRI = (NIRQ + 3) / 4;

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] lanes(input logic [3:0] s);
      logic [31:0] m;
      m = '0;
      for (int b = 0; b < 4; b++)
      begin
         m[8*b +: 8] = {8{s[b]}};
      end
      return m;
   endfunction

   function automatic logic [NIRQ-1:0] onehot(input logic [IRQ_NUM_W-1:0] n);
      logic [NIRQ-1:0] o;
      o = '0;
      for (int i = 0; i < NIRQ; i++)
      begin
         o[i] = (IRQ_NUM_W'(i) == n);
      end
      return o;
   endfunction

   function automatic logic [IRQ_NUM_W:0] pick(input logic [NIRQ-1:0] c,
                                               input logic [NIRQ-1:0][PRI_W-1:0] p);
      logic [IRQ_NUM_W:0] r;
      logic [PRI_W-1:0] bp;
      r = '0;
      bp = '1;
      // Downward scan with <= lets the lower number win a tie
      for (int i = NIRQ - 1; i >= 0; i--)
      begin
         if (c[i] && (p[i] <= bp))
         begin
            r = {1'b1, IRQ_NUM_W'(i)};
            bp = p[i];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Wishbone slave: ack one cycle after the request, effects at the ack edge
   logic ack_q;
   logic [31:0] rdat_q;
   logic flag_rep_q;
   logic [31:0] rd_d;
   logic req;
   logic wr_take;
   logic rd_take;
   logic [31:0] wdat;
   logic [5:0] pri_word;
   logic pri_hit;

   assign req = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr_take = wb_cyc_i && wb_stb_i && ack_q && wb_we_i;
   assign rd_take = wb_cyc_i && wb_stb_i && ack_q && !wb_we_i;
   assign wdat = wb_dat_i & lanes(wb_sel_i);
   assign pri_word = wb_adr_i[7:2] - A_PRI0[7:2];
   assign pri_hit = (wb_adr_i >= A_PRI0) && (pri_word < 6'(NPRI));

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
         rdat_q <= '0;
         flag_rep_q <= 1'b0;
      end
      else
      begin
         ack_q <= req;
         if (req)
         begin
            rdat_q <= rd_d;
            flag_rep_q <= !wb_we_i && (wb_adr_i == A_TCTRL) && rd_d[TICK_FLAG_BIT];
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   ////////////////////////////////////////////////////////////////////////
   // Reset pins: two-flop synchronisers, third flop for edges
   logic [3:0] hw_s1_q;
   logic [3:0] hw_s2_q;
   logic [3:0] hw_s3_q;
   logic [3:0] hw_edge;
   logic hw_lvl;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hw_s1_q <= '0;
         hw_s2_q <= '0;
         hw_s3_q <= '0;
      end
      else
      begin
         hw_s1_q <= {brownout_reset_i, low_voltage_reset_i,
                     watchdog_timeout_reset_i, external_reset_pin_low_i};
         hw_s2_q <= hw_s1_q;
         hw_s3_q <= hw_s2_q;
      end
   end

   assign hw_edge = hw_s2_q & ~hw_s3_q;
   assign hw_lvl = |hw_s2_q;

   ////////////////////////////////////////////////////////////////////////
   // Software reset requests and reset kinds
   logic sw_wr;
   logic sw_sys;
   logic sw_core;
   logic sw_chip;
   logic [2:0] evk;
   logic [RCNT_W-1:0] rcnt_q;
   logic [2:0] kind_q;
   logic blk_rst;

   assign sw_wr = wr_take && (wb_adr_i == A_SWRST);
   assign sw_sys = sw_wr && wdat[SW_SYSREQ];
   assign sw_core = sw_wr && wdat[SW_CORE];
   assign sw_chip = sw_wr && wdat[SW_CHIP];

   always_comb
   begin
      evk = '0;
      evk[K_XTAL] = sw_chip;
      evk[K_PERIPH] = sw_chip || sw_sys || hw_lvl;
      evk[K_CORE] = sw_chip || sw_sys || sw_core || hw_lvl;
   end

   // Held while a pin stays asserted, then stretched by a fixed count
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rcnt_q <= RCNT_W'(RST_HOLD_CYC);
         kind_q <= '1;
      end
      else if (|evk)
      begin
         rcnt_q <= RCNT_W'(RST_HOLD_CYC);
         kind_q <= kind_q | evk;
      end
      else if (rcnt_q != '0)
      begin
         rcnt_q <= rcnt_q - 1'b1;
         if (rcnt_q == RCNT_W'(1))
         begin
            kind_q <= '0;
         end
      end
   end

   assign core_rst_o = kind_q[K_CORE];
   assign periph_rst_o = kind_q[K_PERIPH];
   assign xtal_rst_o = kind_q[K_XTAL];
   // Timer and interrupt state falls with the peripherals
   assign blk_rst = rst_i || kind_q[K_PERIPH];

   ////////////////////////////////////////////////////////////////////////
   // Reset cause flags: survive any reset but power-on
   logic [CAUSE_W-1:0] cause_q;
   logic [CAUSE_W-1:0] cause_set;
   logic [CAUSE_W-1:0] cause_clr;

   always_comb
   begin
      cause_set = '0;
      cause_set[CB_PIN] = hw_edge[0];
      cause_set[CB_WDT] = hw_edge[1];
      cause_set[CB_LVR] = hw_edge[2];
      cause_set[CB_BOD] = hw_edge[3];
      cause_set[CB_SYSREQ] = sw_sys;
      cause_set[CB_CORE] = sw_core;
      cause_set[CB_CHIP] = sw_chip;
      cause_clr = '0;
      if (wr_take && (wb_adr_i == A_CAUSE))
      begin
         cause_clr = wdat[CAUSE_W-1:0];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cause_q <= CAUSE_RST;
      end
      else
      begin
         cause_q <= (cause_q & ~cause_clr) | cause_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Boot select: only power-on and chip one-shot reach it
   logic boot_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i || kind_q[K_XTAL])
      begin
         boot_q <= 1'b0;
      end
      else if (wr_take && (wb_adr_i == A_BOOT) && wb_sel_i[0])
      begin
         boot_q <= wb_dat_i[BOOT_SEL_BIT];
      end
   end

   assign boot_select_bit_o = boot_q;

   ////////////////////////////////////////////////////////////////////////
   // Tick timer control
   logic tick_en_q;
   logic [TW-1:0] reload_q;
   logic flag_q;

   srtim_tick_if #(.W(TW)) tif ();

   assign tif.en = tick_en_q;
   assign tif.reload = reload_q;
   assign tif.cur_wr = wr_take && (wb_adr_i == A_TCUR);

   srtim_tick #(
      .TW(TW)
   ) u_tick (
      .clk_i(clk_i),
      .rst_i(blk_rst),
      .t(tif)
   );

   always_ff @(posedge clk_i)
   begin
      if (blk_rst)
      begin
         tick_en_q <= 1'b0;
         reload_q <= '0;
      end
      else if (wr_take && (wb_adr_i == A_TCTRL))
      begin
         tick_en_q <= wdat[TICK_EN_BIT];
      end
      else if (wr_take && (wb_adr_i == A_TRLD))
      begin
         reload_q <= (reload_q & ~TW'(lanes(wb_sel_i))) | TW'(wdat);
      end
   end

   // Only the value reported clears, so a set in the same cycle stays
   always_ff @(posedge clk_i)
   begin
      if (blk_rst)
      begin
         flag_q <= 1'b0;
         tick_zero_o <= 1'b0;
      end
      else
      begin
         flag_q <= (flag_q && !(rd_take && flag_rep_q)) || tif.zero;
         tick_zero_o <= tif.zero;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt controller state
   logic [NIRQ-1:0] en_q;
   logic [NIRQ-1:0] pend_q;
   logic [NIRQ-1:0] act_q;
   logic [NIRQ-1:0][PRI_W-1:0] pri_q;
   logic [NIRQ-1:0] acc;
   logic [NIRQ-1:0] ret;
   logic [NIRQ-1:0] wsel;
   logic [IRQ_NUM_W:0] best;
   logic irq_req_q;
   logic [IRQ_NUM_W-1:0] irq_num_q;
   logic [31:0] vec_q;

   assign wsel = wdat[NIRQ-1:0];
   assign acc = (irq_accept_i && irq_req_q) ? (onehot(irq_num_q) & pend_q & ~act_q) : '0;
   assign ret = exc_return_i ? onehot(exc_return_num_i) : '0;

   always_ff @(posedge clk_i)
   begin
      if (blk_rst)
      begin
         en_q <= '0;
      end
      else if (wr_take && (wb_adr_i == A_SETEN))
      begin
         en_q <= en_q | wsel;
      end
      else if (wr_take && (wb_adr_i == A_CLREN))
      begin
         en_q <= en_q & ~wsel;
      end
   end

   // Sources pend whether enabled or not; a set beats a clear
   always_ff @(posedge clk_i)
   begin
      if (blk_rst)
      begin
         pend_q <= '0;
      end
      else
      begin
         pend_q <= (pend_q & ~acc & ~((wr_take && (wb_adr_i == A_CLRPND)) ? wsel : '0))
                   | (irq_src_i & ~act_q & ~acc)
                   | ((wr_take && (wb_adr_i == A_SETPND)) ? wsel : '0);
      end
   end

   // Clear-pending writes never reach here
   always_ff @(posedge clk_i)
   begin
      if (blk_rst)
      begin
         act_q <= '0;
      end
      else
      begin
         act_q <= (act_q | acc) & ~ret;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (blk_rst)
      begin
         pri_q <= '0;
      end
      else if (wr_take && pri_hit)
      begin
         for (int k = 0; k < NIRQ; k++)
         begin
            if ((pri_word == 6'(k / 4)) && wb_sel_i[k % 4])
            begin
               pri_q[k] <= wb_dat_i[8*(k % 4) +: PRI_W];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Arbitration: the accepted one is excluded at once, so no double take
   assign best = pick(pend_q & en_q & ~act_q & ~acc, pri_q);

   always_ff @(posedge clk_i)
   begin
      if (blk_rst)
      begin
         irq_req_q <= 1'b0;
         irq_num_q <= '0;
         vec_q <= VEC_BASE;
      end
      else
      begin
         irq_req_q <= best[IRQ_NUM_W];
         irq_num_q <= best[IRQ_NUM_W-1:0];
         vec_q <= VEC_BASE + 32'(VEC_WORD_B * (VEC_EXT_FIRST + int'(best[IRQ_NUM_W-1:0])));
      end
   end

   assign irq_req_o = irq_req_q;
   assign irq_num_o = irq_num_q;
   assign vector_addr_o = vec_q;

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped and write-only words read zero
   always_comb
   begin
      rd_d = '0;
      case (wb_adr_i)
         A_CAUSE: rd_d[CAUSE_W-1:0] = cause_q;
         A_BOOT: rd_d[BOOT_SEL_BIT] = boot_q;
         A_TCTRL:
         begin
            rd_d[TICK_EN_BIT] = tick_en_q;
            rd_d[TICK_FLAG_BIT] = flag_q;
         end
         A_TRLD: rd_d[TW-1:0] = reload_q;
         A_TCUR: rd_d[TW-1:0] = tif.count;
         A_SETEN, A_CLREN: rd_d[NIRQ-1:0] = en_q;
         A_SETPND, A_CLRPND: rd_d[NIRQ-1:0] = pend_q;
         A_ACT: rd_d[NIRQ-1:0] = act_q;
         default:
         begin
            if (pri_hit)
            begin
               for (int k = 0; k < NIRQ; k++)
               begin
                  if (pri_word == 6'(k / 4))
                  begin
                     rd_d[8*(k % 4) +: PRI_W] = pri_q[k];
                  end
               end
            end
         end
      endcase
   end

endmodule
`default_nettype wire

// ==== verification/srtim_top_monitor.sv ====
// Property checker for the reset, tick and interrupt manager
`timescale 1ns/1ps
`default_nettype none
module srtim_top_monitor
   import srtim_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic watchdog_timeout_reset_i,
   input wire logic core_rst_o,
   input wire logic periph_rst_o,
   input wire logic xtal_rst_o,
   input wire logic boot_select_bit_o,
   input wire logic tick_zero_o,
   input wire logic irq_req_o,
   input wire logic [IRQ_NUM_W-1:0] irq_num_o,
   input wire logic [31:0] vector_addr_o,
   input wire logic irq_accept_i
);
   logic sw_wr;
   // Software reset write, taken on the ack edge
   assign sw_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && (wb_adr_i == A_SWRST);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////
   property p_sys_keep;
      sw_wr && wb_dat_i[SW_SYSREQ] && !wb_dat_i[SW_CHIP] |=> (!xtal_rst_o && $stable(boot_select_bit_o))[*6];
   endproperty
   a_sys_keep: assert property (p_sys_keep) else $error("system reset touched crystal or boot bit");
   property p_sys_reach;
      sw_wr && wb_dat_i[SW_SYSREQ] |-> ##[1:3] (core_rst_o && periph_rst_o);
   endproperty
   a_sys_reach: assert property (p_sys_reach) else $error("system reset missed core or peripherals");
   property p_core_only;
      sw_wr && wb_dat_i[2:0] == 3'h2 |-> ##[1:3] (core_rst_o && !periph_rst_o && !xtal_rst_o);
   endproperty
   a_core_only: assert property (p_core_only) else $error("core reset reached too far");
   property p_chip;
      sw_wr && wb_dat_i[SW_CHIP] |-> ##[1:3] (xtal_rst_o && periph_rst_o) ##[0:2] !boot_select_bit_o;
   endproperty
   a_chip: assert property (p_chip) else $error("chip reset incomplete");
   property p_por_hold;
      $fell(rst_i) |-> (core_rst_o && xtal_rst_o)[*3] ##[1:4] !core_rst_o;
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("power-on reset hold wrong");
   property p_hw_rst;
      $rose(watchdog_timeout_reset_i) |-> ##[1:4] (core_rst_o && periph_rst_o && !xtal_rst_o);
   endproperty
   a_hw_rst: assert property (p_hw_rst) else $error("watchdog reset not applied");
   property p_vec;
      irq_req_o |-> vector_addr_o == VEC_BASE + 32'(VEC_WORD_B * (VEC_EXT_FIRST + int'(irq_num_o)));
   endproperty
   a_vec: assert property (p_vec) else $error("vector address mismatch");
   property p_accept;
      irq_accept_i && irq_req_o |=> !irq_req_o || irq_num_o != $past(irq_num_o);
   endproperty
   a_accept: assert property (p_accept) else $error("accepted interrupt offered again");
   property p_quiet;
      periph_rst_o [*3] |-> !irq_req_o && !tick_zero_o;
   endproperty
   a_quiet: assert property (p_quiet) else $error("activity during peripheral reset");
   property p_tick_pulse;
      tick_zero_o |=> !tick_zero_o;
   endproperty
   a_tick_pulse: assert property (p_tick_pulse) else $error("zero pulse too long");
endmodule
bind srtim_top srtim_top_monitor u_srtim_top_monitor (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .watchdog_timeout_reset_i(watchdog_timeout_reset_i), .core_rst_o(core_rst_o), .periph_rst_o(periph_rst_o),
   .xtal_rst_o(xtal_rst_o), .boot_select_bit_o(boot_select_bit_o), .tick_zero_o(tick_zero_o),
   .irq_req_o(irq_req_o), .irq_num_o(irq_num_o), .vector_addr_o(vector_addr_o), .irq_accept_i(irq_accept_i));
`default_nettype wire

// ==== verification/srtim_core_model.sv ====
// Behavioural processor core taking offered interrupts
`timescale 1ns/1ps
`default_nettype none
module srtim_core_model
   import srtim_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic [3:0] wait_i,
   input wire logic [7:0] svc_i,
   input wire logic irq_req_i,
   input wire logic [IRQ_NUM_W-1:0] irq_num_i,
   output logic irq_accept_o,
   output logic exc_return_o,
   output logic [IRQ_NUM_W-1:0] exc_num_o
);
   logic acc_q = 1'b0;
   logic ret_q = 1'b0;
   logic busy_q = 1'b0;
   logic [IRQ_NUM_W-1:0] num_q = '0;
   logic [7:0] cnt_q = 8'h00;
   assign irq_accept_o = acc_q;
   assign exc_return_o = ret_q;
   assign exc_num_o = num_q;
   // One handler at a time; the block has no preemption to exercise
   always_ff @(posedge clk_i)
   begin
      acc_q <= 1'b0;
      ret_q <= 1'b0;
      if (rst_i)
      begin
         busy_q <= 1'b0;
         cnt_q <= 8'h00;
      end
      else if (busy_q)
      begin
         cnt_q <= cnt_q + 8'h01;
         // Number latched as offered at the accept edge
         if (cnt_q == 8'h00)
            num_q <= irq_num_i;
         if (cnt_q == svc_i)
         begin
            ret_q <= 1'b1;
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
         end
      end
      else if (go_i && irq_req_i)
      begin
         cnt_q <= cnt_q + 8'h01;
         if (cnt_q >= {4'h0, wait_i})
         begin
            acc_q <= 1'b1;
            busy_q <= 1'b1;
            cnt_q <= 8'h00;
         end
      end
      else
         cnt_q <= 8'h00;
   end
endmodule
`default_nettype wire

// ==== verification/tb_srtim_top.sv ====
// Self-checking bench for the reset, tick and interrupt manager
`timescale 1ns/1ps
`default_nettype none
module tb_srtim_top;
   import srtim_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [3:0] hw = 4'h0;
   logic [7:0] src = 8'h00;
   logic go = 1'b0;
   logic [3:0] wt = 4'h0;
   logic [31:0] rdat, vec;
   logic ack, core_r, per_r, xt_r, boot, tz, req, acc, ret;
   logic [IRQ_NUM_W-1:0] num, rnum;
   logic [63:0] q_rd[$];
   logic [IRQ_NUM_W-1:0] q_irq[$];
   int q_tp[$];
   int num_errors = 0;
   int checks = 0;
   int cyc_n = 0;
   int last = 0;
   int rlen = 0;
   integer seed = 32'hC13C;
   logic [63:0] e;
   always #25 clk_i = ~clk_i;
   srtim_top u_srtim_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .external_reset_pin_low_i(hw[0]), .watchdog_timeout_reset_i(hw[1]), .low_voltage_reset_i(hw[2]),
      .brownout_reset_i(hw[3]), .core_rst_o(core_r), .periph_rst_o(per_r), .xtal_rst_o(xt_r),
      .boot_select_bit_o(boot), .tick_zero_o(tz), .irq_src_i(src), .irq_req_o(req), .irq_num_o(num),
      .vector_addr_o(vec), .irq_accept_i(acc), .exc_return_i(ret), .exc_return_num_i(rnum));
   srtim_core_model u_srtim_core_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .wait_i(wt), .svc_i(8'h28),
      .irq_req_i(req), .irq_num_i(num), .irq_accept_o(acc), .exc_return_o(ret), .exc_num_o(rnum));
   ////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
      checks++;
      if (g !== x)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, x, g);
      end
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Watcher: every result is matched against the oldest note
   always @(posedge clk_i)
   begin
      if (ack === 1'b1 && we === 1'b0 && q_rd.size() > 0)
      begin
         e = q_rd.pop_front();
         cmp($sformatf("reg %h", adr), e[31:0], rdat & e[63:32]);
      end
      if (acc === 1'b1 && q_irq.size() > 0)
      begin
         cmp("irq number", 32'(q_irq[0]), 32'(num));
         cmp("vector", VEC_BASE + 32'(VEC_WORD_B * (VEC_EXT_FIRST + int'(q_irq[0]))), vec);
         void'(q_irq.pop_front());
      end
      if (tz === 1'b1)
      begin
         if (q_tp.size() > 0)
            cmp("tick period", q_tp.pop_front(), cyc_n - last);
         last = cyc_n;
      end
      cyc_n++;
      // Whole run needs well under two thousand cycles
      if (cyc_n > 5000)
      begin
         num_errors++;
         report_and_stop;
      end
   end
   task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1)
         @(posedge clk_i);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = 32'hFFFFFFFF);
      q_rd.push_back({m, x});
      wb(a, 1'b0, 32'h0);
   endtask
   // Reset must first take hold, then fully let go
   task settle;
      while (core_r !== 1'b1)
         @(posedge clk_i);
      while (core_r !== 1'b0 || per_r !== 1'b0)
         @(posedge clk_i);
   endtask
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      settle;
      rd(A_CAUSE, 32'(CAUSE_RST));
      rd(A_BOOT, 32'h0);
      rd(8'hFC, 32'h0);
      $display("test reset defaults done");
      for (int i = 0; i < 4; i++)
      begin
         hw[i] <= 1'b1;
         repeat (3) @(posedge clk_i);
         hw[i] <= 1'b0;
         settle;
         rd(A_CAUSE, (32'h4 << i) - 32'h1);
      end
      wb(A_CAUSE, 1'b1, 32'h1E);
      rd(A_CAUSE, 32'(CAUSE_RST));
      $display("test hardware causes done");
      wb(A_BOOT, 1'b1, 32'h2);
      wb(A_SETEN, 1'b1, 32'hFF);
      wb(A_SWRST, 1'b1, 32'h2);
      settle;
      rd(A_SETEN, 32'hFF);
      wb(A_SWRST, 1'b1, 32'h4);
      settle;
      rd(A_BOOT, 32'h2);
      rd(A_SETEN, 32'h0);
      wb(A_SWRST, 1'b1, 32'h1);
      settle;
      rd(A_BOOT, 32'h0);
      rd(A_CAUSE, 32'hE1);
      $display("test software resets done");
      rlen = 3 + ($random(seed) & 7);
      wb(A_TRLD, 1'b1, 32'hFFFFFFFF);
      rd(A_TRLD, 32'h00FFFFFF);
      wb(A_TRLD, 1'b1, 32'(rlen));
      wb(A_TCTRL, 1'b1, 32'h1);
      while (tz !== 1'b1)
         @(posedge clk_i);
      @(posedge clk_i);
      q_tp.push_back(rlen + 1);
      q_tp.push_back(rlen + 1);
      while (q_tp.size() > 0)
         @(posedge clk_i);
      wb(A_TCTRL, 1'b1, 32'h0);
      rd(A_TCTRL, 32'h00010000);
      rd(A_TCTRL, 32'h0);
      wb(A_TCUR, 1'b1, 32'h123);
      rd(A_TCUR, 32'h0);
      wb(A_TRLD, 1'b1, 32'h0);
      wb(A_TCTRL, 1'b1, 32'h1);
      repeat (20) @(posedge clk_i);
      rd(A_TCUR, 32'h0);
      rd(A_TCTRL, 32'h1);
      $display("test tick timer done");
      src[3] <= 1'b1;
      repeat (3) @(posedge clk_i);
      src[3] <= 1'b0;
      rd(A_SETPND, 32'h08);
      rd(A_ACT, 32'h0);
      wb(A_SETEN, 1'b1, 32'h28);
      wb(A_CLREN, 1'b1, 32'h20);
      rd(A_CLREN, 32'h08);
      wb(A_SETPND, 1'b1, 32'h20);
      wb(A_CLRPND, 1'b1, 32'h08);
      rd(A_CLRPND, 32'h20);
      wb(A_SETPND, 1'b1, 32'h08);
      wb(A_PRI0, 1'b1, 32'h80000000);
      wb(A_PRI0 + 8'h04, 1'b1, 32'h00001000);
      rd(A_PRI0, 32'h80000000);
      wb(A_SETEN, 1'b1, 32'h20);
      q_irq.push_back(5'h05);
      q_irq.push_back(5'h03);
      wt <= 4'($random(seed) & 3);
      go <= 1'b1;
      while (q_irq.size() > 1)
         @(posedge clk_i);
      wb(A_CLREN, 1'b1, 32'h20);
      wb(A_CLRPND, 1'b1, 32'h20);
      rd(A_ACT, 32'h20);
      rd(A_SETPND, 32'h08);
      while (q_irq.size() > 0)
         @(posedge clk_i);
      while (ret !== 1'b1)
         @(posedge clk_i);
      @(posedge clk_i);
      rd(A_ACT, 32'h0);
      $display("test interrupts done");
      report_and_stop;
   end
endmodule
`default_nettype wire
